// ### inc/acfm_pkg.sv
package acfm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_SCNT = 8'h04;
  localparam logic [7:0] OFF_SNUM = 8'h08;
  localparam logic [7:0] OFF_CYLL = 8'h0c;
  localparam logic [7:0] OFF_CYLH = 8'h10;
  localparam logic [7:0] OFF_DRVH = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam logic [7:0] OFF_LBA = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h24;
  localparam logic [7:0] OFF_FAIL = 8'h28;
  localparam logic [7:0] OFF_MAP = 8'h2c;
  localparam logic [7:0] OFF_DATA = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRV_BIT = 4;
  localparam int FAIL_VLD_BIT = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_WBLK_BIT = 3;
  localparam int ST_FREE_LSB = 4;
  localparam int ST_FREE_W = 5;
  localparam int ST_IDX_LSB = 12;

  // ----------------------------------------------------------------
  // block table geometry
  // ----------------------------------------------------------------
  localparam int NBLK = 16;
  localparam int NLOG = 12;
  localparam int BLK_W = 4;
  localparam int BLK_SHIFT = 8;
  localparam logic [ST_FREE_W-1:0] FREE_MIN = 5'h02;
  localparam logic [BLK_W:0] NLOG_W = 5'h0c;

  localparam logic [1:0] CLS_NORMAL = 2'h0;
  localparam logic [1:0] CLS_FREE = 2'h1;
  localparam logic [1:0] CLS_BAD = 2'h2;

  // ----------------------------------------------------------------
  // data path and error correction
  // ----------------------------------------------------------------
  localparam int DW = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int SECT_BYTES = 512;
  localparam int SECT_WORDS = SECT_BYTES / (DW / 8);
  localparam int SECT_CW = 7;
  localparam int ECC_T_LOW = 8;
  localparam int ECC_T_HIGH = 15;

  // ----------------------------------------------------------------
  // command kinds and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_READ = 3'h1,
    K_WRITE = 3'h2,
    K_VERIFY = 3'h3,
    K_SEEK = 3'h4,
    K_SUBCMD = 3'h5,
    K_CTRL = 3'h6
  } acfm_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DECODE = 3'b010,
    S_ISSUE = 3'b100
  } acfm_state_t;

  typedef struct packed {
    acfm_kind_t kind;
    logic [7:0] opcode;
    logic [7:0] subcmd;
    logic [7:0] count;
    logic [7:0] sector;
    logic [15:0] cyl;
    logic drive;
    logic [3:0] head;
    logic lba_mode;
    logic [27:0] lba;
    logic [BLK_W-1:0] pblk;
  } acfm_cmd_t;

  typedef struct packed {
    acfm_kind_t kind;
    logic fr;
    logic sc;
    logic sn;
    logic cy;
    logic hd;
  } acfm_use_t;

endpackage

// ### logic/acfm_fifo.sv
`timescale 1ns/10ps
module acfm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rptr_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop)
      begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (push != pop)
      begin
        cnt_q <= push ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### logic/acfm_top.sv
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/10ps
module acfm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output acfm_pkg::acfm_cmd_t cmd_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic [acfm_pkg::DW-1:0] flash_dat_o,
  output logic flash_valid_o,
  input wire logic flash_ready_i,
  output logic sect_end_o,
  output logic ecc_strong_o,
  output logic wr_blocked_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr_ok;
  logic lane0;
  logic sel_cmd;
  logic sel_data;
  logic sel_fail;
  logic fifo_in_ready;
  logic stall;

  assign req = wb_cyc_i & wb_stb_i;
  assign lane0 = wb_sel_i[0];
  assign sel_cmd = (wb_adr_i == acfm_pkg::OFF_CMD);
  assign sel_data = (wb_adr_i == acfm_pkg::OFF_DATA);
  assign sel_fail = (wb_adr_i == acfm_pkg::OFF_FAIL);
  // a full fifo holds off the ack, so the bus master is stalled
  assign stall = wb_we_i & sel_data & ~fifo_in_ready;
  assign wr_ok = req & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // taskfile registers
  // ----------------------------------------------------------------
  logic [7:0] feat_q;
  logic [7:0] scnt_q;
  logic [7:0] snum_q;
  logic [7:0] cyll_q;
  logic [7:0] cylh_q;
  logic [7:0] drvh_q;
  logic [7:0] op_q;
  logic ctrl_q;
  logic [acfm_pkg::BLK_W-1:0] mapsel_q;
  logic err_q;
  acfm_pkg::acfm_state_t st_q;
  acfm_pkg::acfm_state_t st_d;
  acfm_pkg::acfm_cmd_t cmd_q;
  acfm_pkg::acfm_cmd_t cmd_d;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      feat_q <= 8'h00;
      scnt_q <= 8'h00;
      snum_q <= 8'h00;
      cyll_q <= 8'h00;
      cylh_q <= 8'h00;
      drvh_q <= 8'h00;
      ctrl_q <= 1'b0;
      mapsel_q <= '0;
    end
    else if (wr_ok && lane0)
    begin
      case (wb_adr_i)
        acfm_pkg::OFF_FEAT: feat_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_SCNT: scnt_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_SNUM: snum_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_CYLL: cyll_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_CYLH: cylh_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_DRVH: drvh_q <= wb_dat_i[7:0];
        acfm_pkg::OFF_CTRL: ctrl_q <= wb_dat_i[0];
        acfm_pkg::OFF_MAP: mapsel_q <= wb_dat_i[acfm_pkg::BLK_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // opcode classification
  // ----------------------------------------------------------------
  function automatic acfm_pkg::acfm_use_t classify(input logic [7:0] op);
    acfm_pkg::acfm_use_t u;
    u = '0;
    case (op)
      8'hc8, 8'hc9, 8'hc4, 8'h20, 8'h21:
      begin
        u = {acfm_pkg::K_READ, 5'b01111};
      end
      8'hca, 8'hc5, 8'h30:
      begin
        u = {acfm_pkg::K_WRITE, 5'b01111};
      end
      8'h40, 8'h41:
      begin
        u = {acfm_pkg::K_VERIFY, 5'b01111};
      end
      8'h91:
      begin
        u = {acfm_pkg::K_CTRL, 5'b01001};
      end
      8'he3, 8'hc6:
      begin
        u = {acfm_pkg::K_CTRL, 5'b01000};
      end
      8'hef:
      begin
        u = {acfm_pkg::K_SUBCMD, 5'b10000};
      end
      8'hb0:
      begin
        u = {acfm_pkg::K_SUBCMD, 5'b11110};
      end
      8'he5, 8'h90, 8'he7, 8'hec, 8'he1, 8'h10, 8'he6, 8'he2,
      8'he0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6:
      begin
        u = {acfm_pkg::K_CTRL, 5'b00000};
      end
      default:
      begin
        if (op[7:4] == 4'h7)
        begin
          u = {acfm_pkg::K_SEEK, 5'b00011};
        end
        else
        begin
          u = {acfm_pkg::K_NONE, 5'b00000};
        end
      end
    endcase
    return u;
  endfunction

  // ----------------------------------------------------------------
  // block table
  // ----------------------------------------------------------------
  logic [1:0] cls_q [acfm_pkg::NBLK];
  logic [acfm_pkg::BLK_W-1:0] map_q [acfm_pkg::NLOG];
  logic [acfm_pkg::ST_FREE_W-1:0] free_cnt;
  logic [acfm_pkg::BLK_W-1:0] free_idx;
  logic free_any;
  logic [acfm_pkg::BLK_W-1:0] fail_log;
  logic fail_hit;
  logic [acfm_pkg::BLK_W-1:0] fail_blk;
  logic fail_go;

  assign fail_blk = wb_dat_i[acfm_pkg::BLK_W-1:0];
  assign fail_go = wr_ok & lane0 & sel_fail
                 & wb_sel_i[1] & wb_dat_i[acfm_pkg::FAIL_VLD_BIT];

  always_comb
  begin
    free_cnt = '0;
    free_idx = '0;
    free_any = 1'b0;
    for (int i = acfm_pkg::NBLK - 1; i >= 0; i--)
    begin
      if (cls_q[i] == acfm_pkg::CLS_FREE)
      begin
        free_cnt = free_cnt + 1'b1;
        free_idx = i[acfm_pkg::BLK_W-1:0];
        free_any = 1'b1;
      end
    end
  end

  always_comb
  begin
    fail_log = '0;
    fail_hit = 1'b0;
    for (int i = 0; i < acfm_pkg::NLOG; i++)
    begin
      if (map_q[i] == fail_blk)
      begin
        fail_log = i[acfm_pkg::BLK_W-1:0];
        fail_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < acfm_pkg::NBLK; i++)
      begin
        cls_q[i] <= (i < acfm_pkg::NLOG) ? acfm_pkg::CLS_NORMAL
                                          : acfm_pkg::CLS_FREE;
      end
      for (int i = 0; i < acfm_pkg::NLOG; i++)
      begin
        map_q[i] <= i[acfm_pkg::BLK_W-1:0];
      end
    end
    else if (fail_go)
    begin
      if (cls_q[fail_blk] == acfm_pkg::CLS_NORMAL)
      begin
        cls_q[fail_blk] <= acfm_pkg::CLS_BAD;
        if (free_any && fail_hit)
        begin
          cls_q[free_idx] <= acfm_pkg::CLS_NORMAL;
          map_q[fail_log] <= free_idx;
        end
      end
      else if (cls_q[fail_blk] == acfm_pkg::CLS_FREE)
      begin
        cls_q[fail_blk] <= acfm_pkg::CLS_BAD;
      end
    end
  end

  assign wr_blocked_o = (free_cnt <= acfm_pkg::FREE_MIN);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  acfm_pkg::acfm_use_t use_w;
  logic lba_mode;
  logic [27:0] lba_w;
  logic [acfm_pkg::BLK_W:0] lblk;
  logic in_range;
  logic xfer;
  logic refuse;
  logic cmd_go;

  assign use_w = classify(op_q);
  assign lba_mode = drvh_q[acfm_pkg::DH_LBA_BIT];
  assign lba_w = {drvh_q[3:0], cylh_q, cyll_q, snum_q};
  assign lblk = {1'b0,
    lba_w[acfm_pkg::BLK_SHIFT +: acfm_pkg::BLK_W]};
  assign in_range = ~lba_mode | (lblk < acfm_pkg::NLOG_W);
  assign xfer = (use_w.kind == acfm_pkg::K_READ)
              | (use_w.kind == acfm_pkg::K_WRITE)
              | (use_w.kind == acfm_pkg::K_VERIFY);
  // an unknown opcode or an LBA transfer whose block (LBA bits 11:8) lies past the map never reaches flash
  assign refuse = (use_w.kind == acfm_pkg::K_NONE)
                | ((use_w.kind == acfm_pkg::K_WRITE) & wr_blocked_o)
                | (xfer & ~in_range);
  assign cmd_go = wr_ok & lane0 & sel_cmd
                & (st_q == acfm_pkg::S_IDLE);

  always_comb
  begin
    cmd_d = '0;
    cmd_d.kind = use_w.kind;
    cmd_d.opcode = op_q;
    cmd_d.subcmd = use_w.fr ? feat_q : 8'h00;
    cmd_d.count = use_w.sc ? scnt_q : 8'h00;
    cmd_d.sector = use_w.sn ? snum_q : 8'h00;
    cmd_d.cyl = use_w.cy ? {cylh_q, cyll_q} : 16'h0000;
    cmd_d.drive = drvh_q[acfm_pkg::DH_DRV_BIT];
    cmd_d.head = use_w.hd ? drvh_q[3:0] : 4'h0;
    cmd_d.lba_mode = xfer & lba_mode;
    cmd_d.lba = (xfer & lba_mode) ? lba_w : 28'h0000000;
    cmd_d.pblk = (xfer & lba_mode) ? map_q[lblk[acfm_pkg::BLK_W-1:0]]
                                   : '0;
  end

  always_comb
  begin
    case (st_q)
      acfm_pkg::S_IDLE: st_d = cmd_go ? acfm_pkg::S_DECODE : st_q;
      acfm_pkg::S_DECODE: st_d = refuse ? acfm_pkg::S_IDLE
                                        : acfm_pkg::S_ISSUE;
      acfm_pkg::S_ISSUE: st_d = cmd_ready_i ? acfm_pkg::S_IDLE : st_q;
      default: st_d = acfm_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= acfm_pkg::S_IDLE;
      op_q <= 8'h00;
      err_q <= 1'b0;
      cmd_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      if (cmd_go)
      begin
        op_q <= wb_dat_i[7:0];
        err_q <= 1'b0;
      end
      if (st_q == acfm_pkg::S_DECODE)
      begin
        err_q <= refuse;
        cmd_q <= refuse ? cmd_q : cmd_d;
      end
    end
  end

  assign cmd_o = cmd_q;
  assign cmd_valid_o = (st_q == acfm_pkg::S_ISSUE);

  // ----------------------------------------------------------------
  // write data path and sector framing
  // ----------------------------------------------------------------
  logic fifo_push;
  logic fifo_out_valid;
  logic [acfm_pkg::SECT_CW-1:0] word_q;
  logic sect_q;
  logic pop;

  assign fifo_push = req & wb_we_i & sel_data & ~ack_q;

  acfm_fifo #(
    .WIDTH(acfm_pkg::DW),
    .DEPTH(acfm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wb_dat_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(flash_ready_i),
    .out_data_o(flash_dat_o)
  );

  assign flash_valid_o = fifo_out_valid;
  assign pop = fifo_out_valid & flash_ready_i;

  // the coder closes its parity at each sector boundary
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_q <= '0;
      sect_q <= 1'b0;
    end
    else
    begin
      sect_q <= pop & (word_q == 7'(acfm_pkg::SECT_WORDS - 1));
      if (pop)
      begin
        word_q <= word_q + 1'b1;
      end
    end
  end

  assign sect_end_o = sect_q;
  assign ecc_strong_o = ctrl_q;

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  logic [31:0] stat_w;

  // the abort bit always follows the error bit, so err_q shows twice
  assign stat_w = {16'h0000, cmd_q.pblk, 3'b000,
    free_cnt, wr_blocked_o, err_q, err_q,
    st_q != acfm_pkg::S_IDLE};

  always_comb
  begin
    case (wb_adr_i)
      acfm_pkg::OFF_FEAT: rmux = {24'h000000, feat_q};
      acfm_pkg::OFF_SCNT: rmux = {24'h000000, scnt_q};
      acfm_pkg::OFF_SNUM: rmux = {24'h000000, snum_q};
      acfm_pkg::OFF_CYLL: rmux = {24'h000000, cyll_q};
      acfm_pkg::OFF_CYLH: rmux = {24'h000000, cylh_q};
      acfm_pkg::OFF_DRVH: rmux = {24'h000000, drvh_q};
      acfm_pkg::OFF_CMD: rmux = {24'h000000, op_q};
      acfm_pkg::OFF_STAT: rmux = stat_w;
      acfm_pkg::OFF_LBA: rmux = {4'h0, cmd_q.lba};
      acfm_pkg::OFF_CTRL: rmux = {31'h00000000, ctrl_q};
      acfm_pkg::OFF_MAP: rmux = {20'h00000, cls_q[mapsel_q], 2'h0,
        (mapsel_q < acfm_pkg::NLOG) ? map_q[mapsel_q] : 4'h0, mapsel_q};
      default: rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req & ~ack_q & ~stall;
      if (req && !ack_q)
      begin
        rdat_q <= rmux;
      end
    end
  end
endmodule

// ### test/acfm_flash_model.sv
`timescale 1ns/10ps
module acfm_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire acfm_pkg::acfm_cmd_t cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic flash_valid_i,
  output logic flash_ready_o,
  output acfm_pkg::acfm_cmd_t last_cmd_o,
  output logic [7:0] cmd_cnt_o
);
  // ready follows the bench's stall choice so prompt and slow answers
  // both occur; a long stall lets the data fifo fill up
  assign cmd_ready_o = !stall_i;
  assign flash_ready_o = !stall_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd_cnt_o <= 8'h00;
    else if (cmd_valid_i && cmd_ready_o)
    begin
      cmd_cnt_o <= cmd_cnt_o + 8'h01;
      last_cmd_o <= cmd_i;
    end
  end
endmodule

// ### test/acfm_top_sva.sv
`timescale 1ns/10ps
module acfm_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire acfm_pkg::acfm_cmd_t cmd_o,
  input wire logic cmd_valid_o,
  input wire logic cmd_ready_i,
  input wire logic flash_valid_o,
  input wire logic flash_ready_i,
  input wire logic sect_end_o,
  input wire logic wr_blocked_o
);
  logic [6:0] pop_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // popped words within the current sector
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pop_q <= 7'h00;
    else if (flash_valid_o && flash_ready_i)
      pop_q <= pop_q + 7'h01;
  end
  sequence s_last_pop;
    flash_valid_o && flash_ready_i && pop_q == 7'h7f;
  endsequence
  sequence s_waiting;
    cmd_valid_o && !cmd_ready_i;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
    else $error("ack without a request");
  cmd_hold_a: assert property (s_waiting |=> cmd_valid_o && $stable(cmd_o))
    else $error("command changed before ready");
  known_op_a: assert property ($rose(cmd_valid_o) |->
    cmd_o.kind != acfm_pkg::K_NONE) else $error("unknown opcode issued");
  wr_block_a: assert property (cmd_valid_o &&
    cmd_o.kind == acfm_pkg::K_WRITE |-> !wr_blocked_o)
    else $error("write issued while blocked");
  seek_use_a: assert property (cmd_valid_o &&
    cmd_o.kind == acfm_pkg::K_SEEK |-> {cmd_o.count, cmd_o.sector} == 16'h0)
    else $error("seek carries count or sector");
  sub_only_a: assert property (cmd_valid_o &&
    cmd_o.kind != acfm_pkg::K_SUBCMD |-> cmd_o.subcmd == 8'h00)
    else $error("features decoded for wrong opcode");
  drv_only_a: assert property (cmd_valid_o && (cmd_o.opcode[7:5] == 3'h7 ||
    cmd_o.opcode == 8'h90) |-> cmd_o.head == 4'h0)
    else $error("head bits used for drive-only command");
  cnt_skip_a: assert property (cmd_valid_o && cmd_o.opcode[7:4] == 4'he &&
    cmd_o.opcode != 8'he3 |-> cmd_o.count == 8'h00)
    else $error("sector count used where ignored");
  lba_map_a: assert property (cmd_valid_o && cmd_o.lba_mode |->
    cmd_o.lba[11:8] < 4'hc) else $error("logical block out of range");
  sect_end_a: assert property (s_last_pop |=> sect_end_o)
    else $error("no sector end after last word");
  sect_one_a: assert property (sect_end_o |=> !sect_end_o)
    else $error("sector end longer than one cycle");
endmodule
bind acfm_top acfm_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cmd_o, .cmd_valid_o, .cmd_ready_i, .flash_valid_o, .flash_ready_i,
  .sect_end_o, .wr_blocked_o);

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, flash_dat_o, rd, st;
  logic wb_ack_o, cmd_valid_o, cmd_ready_i, flash_valid_o, flash_ready_i;
  logic sect_end_o, ecc_strong_o, wr_blocked_o;
  logic hold_q = 1'b0;
  logic stall_q = 1'b1;
  logic [15:0] rnd_q = 16'hc3c9;
  logic [7:0] ncmd, n0, fe, sc, sn, cl, ch, dh;
  logic [3:0] lg;
  logic [3:0] map_e [12];
  logic [7:0] ops [10] = '{8'hc8, 8'hc9, 8'hc4, 8'h20, 8'h21, 8'hca, 8'hc5,
    8'h30, 8'h40, 8'h41};
  logic [7:0] bad [3] = '{8'h00, 8'hff, 8'h35};
  logic [31:0] exp_q [$];
  acfm_pkg::acfm_cmd_t cmd_o, lc;
  int error_cnt = 0;
  int check_count = 0;
  int sect_cnt = 0;
  int i;
  acfm_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_o, .cmd_valid_o,
    .cmd_ready_i, .flash_dat_o, .flash_valid_o, .flash_ready_i, .sect_end_o,
    .ecc_strong_o, .wr_blocked_o);
  acfm_flash_model u_far (.clk_i, .rst_i, .stall_i(stall_q), .cmd_i(cmd_o),
    .cmd_valid_i(cmd_valid_o), .cmd_ready_o(cmd_ready_i),
    .flash_valid_i(flash_valid_o), .flash_ready_o(flash_ready_i),
    .last_cmd_o(lc), .cmd_cnt_o(ncmd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [2:0] kind_of(input int k);
    return k < 5 ? acfm_pkg::K_READ : k < 8 ? acfm_pkg::K_WRITE
      : acfm_pkg::K_VERIFY;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 4000);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tmo(n, 4000);
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] op, c, d);
    int j;
    fe = rnd_q[7:0];
    sc = rnd_q[15:8];
    sn = rnd_q[11:4];
    ch = rnd_q[13:6];
    cl = c;
    dh = d;
    wb(1'b1, acfm_pkg::OFF_FEAT, {24'h0, fe});
    wb(1'b1, acfm_pkg::OFF_SCNT, {24'h0, sc});
    wb(1'b1, acfm_pkg::OFF_SNUM, {24'h0, sn});
    wb(1'b1, acfm_pkg::OFF_CYLL, {24'h0, cl});
    wb(1'b1, acfm_pkg::OFF_CYLH, {24'h0, ch});
    wb(1'b1, acfm_pkg::OFF_DRVH, {24'h0, dh});
    n0 = ncmd;
    wb(1'b1, acfm_pkg::OFF_CMD, {24'h0, op});
    j = 0;
    do
    begin
      wb(1'b0, acfm_pkg::OFF_STAT, 32'h0);
      j++;
    end while (rd[0] !== 1'b0 && j < 100);
    tmo(j, 100);
    st = rd;
  endtask
  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask
  always #20 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // random stalls and the flash-side data monitor
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    rnd_q <= lfsr(rnd_q);
    stall_q <= hold_q | (rnd_q[1:0] == 2'h0);
    if (flash_valid_o && flash_ready_i)
      chk(flash_dat_o, exp_q.pop_front());
    if (sect_end_o === 1'b1)
      sect_cnt++;
  end
  initial
  begin
    for (int k = 0; k < 12; k++)
      map_e[k] = 4'(k);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, acfm_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h40);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, acfm_pkg::OFF_CTRL, 32'h1);
    chk(ecc_strong_o, 1'b1);
    wb(1'b1, acfm_pkg::OFF_CTRL, 32'h0);
    chk(ecc_strong_o, 1'b0);
    done_t("regs");
    for (int k = 0; k < 10; k++)
    begin
      lg = 4'(rnd_q[3:0] % 4'hc);
      cmd(ops[k], {rnd_q[7:4], lg}, {3'h2, rnd_q[9], rnd_q[13:10]});
      chk({ncmd - n0, st[3:0]}, {8'h01, 4'h0});
      chk({lc.kind, lc.pblk, lc.count, lc.drive},
        {kind_of(k), map_e[lg], sc, dh[4]});
      chk(lc.lba, {dh[3:0], ch, cl, sn});
    end
    done_t("transfers");
    foreach (bad[k])
    begin
      cmd(bad[k], 8'h00, 8'h40);
      chk({ncmd - n0, st[2:1]}, {8'h00, 2'h3});
    end
    cmd({4'h7, rnd_q[3:0]}, rnd_q[15:8], {3'h0, rnd_q[4], rnd_q[11:8]});
    chk({lc.kind, lc.count, lc.sector, lc.head, lc.drive},
      {acfm_pkg::K_SEEK, 16'h0, dh[3:0], dh[4]});
    chk(lc.cyl, {ch, cl});
    cmd(8'hef, 8'h00, 8'h1f);
    chk({lc.subcmd, lc.count, lc.head, lc.drive}, {fe, 8'h0, 4'h0, 1'b1});
    cmd(8'he3, 8'h00, 8'h0f);
    chk({lc.subcmd, lc.count, lc.head}, {8'h0, sc, 4'h0});
    cmd(8'hb0, 8'h00, 8'h00);
    chk({lc.subcmd, lc.count}, {fe, sc});
    cmd(8'h91, 8'h00, 8'h0a);
    chk({lc.kind, lc.count, lc.sector, lc.head, lc.drive},
      {acfm_pkg::K_CTRL, sc, 8'h0, 4'ha, 1'b0});
    done_t("fields");
    hold_q <= 1'b1;
    fork
      for (int k = 0; k < 128; k++)
      begin
        exp_q.push_back({rnd_q, lfsr(rnd_q)});
        wb(1'b1, acfm_pkg::OFF_DATA, exp_q[$]);
      end
      begin
        repeat (60) @(posedge clk_i);
        hold_q <= 1'b0;
      end
    join
    i = 0;
    while (exp_q.size() > 0 && i < 500)
    begin
      @(posedge clk_i);
      i++;
    end
    tmo(i, 500);
    repeat (4) @(posedge clk_i);
    chk(sect_cnt, 1);
    done_t("fifo");
    wb(1'b1, acfm_pkg::OFF_FAIL, 32'h103);
    map_e[3] = 4'hc;
    wb(1'b1, acfm_pkg::OFF_MAP, 32'h3);
    wb(1'b0, acfm_pkg::OFF_MAP, 32'h0);
    chk(rd, {20'h0, acfm_pkg::CLS_BAD, 2'h0, 4'hc, 4'h3});
    wb(1'b1, acfm_pkg::OFF_FAIL, 32'h10d);
    wb(1'b1, acfm_pkg::OFF_MAP, 32'hd);
    wb(1'b0, acfm_pkg::OFF_MAP, 32'h0);
    chk(rd, {20'h0, acfm_pkg::CLS_BAD, 6'h0, 4'hd});
    wb(1'b0, acfm_pkg::OFF_STAT, 32'h0);
    chk({rd[8:3], wr_blocked_o}, {5'h02, 2'h3});
    cmd(8'hca, 8'h03, 8'h40);
    chk({ncmd - n0, st[1]}, {8'h00, 1'b1});
    cmd(8'hc8, 8'h03, 8'h40);
    chk({ncmd - n0, lc.pblk}, {8'h01, 4'hc});
    done_t("blocks");
    finish_test();
  end
endmodule
